// ### common/rmc_pkg.sv
// rmc_pkg: register map, field layout, reset values and lookup tables for
// the modulation configuration register bank.
// assumes a 32-bit AHB-Lite bus, one aligned word per register.
//
// Contract
// - bit 7 low enables regulator AM
// - bit 6 makes the pin active low
// - bit 5 puts load modulation on pin
// - bit 4 enables driver load modulation, resets set
// - bit 3 enables resistive AM with level field
// - bit 2 enables shaped regulator AM, resets clear
// - bits 7:4 modulated drive level, reset 0111
// - bits 3:0 unmodulated drive level, reset 0
// - level code maps monotonic, 15 is high impedance
// - depth index maps 0 to 82 percent
`default_nettype none

package rmc_pkg;

  // printed register indices; byte address is four times the index
  localparam logic [7:0]  AUX_IDX      = 8'h28;
  localparam logic [7:0]  PTM_IDX      = 8'h29;
  localparam logic [7:0]  MODLVL_IDX   = 8'h30;
  localparam logic [7:0]  STATUS_IDX   = 8'h31;
  localparam logic [31:0] AUX_ADDR     = {22'h0, AUX_IDX, 2'h0};
  localparam logic [31:0] PTM_ADDR     = {22'h0, PTM_IDX, 2'h0};
  localparam logic [31:0] MODLVL_ADDR  = {22'h0, MODLVL_IDX, 2'h0};
  localparam logic [31:0] STATUS_ADDR  = {22'h0, STATUS_IDX, 2'h0};

  // auxiliary modulation register bit positions
  localparam int unsigned AUX_REG_OFF_BIT  = 7;
  localparam int unsigned AUX_PIN_POL_BIT  = 6;
  localparam int unsigned AUX_PIN_EN_BIT   = 5;
  localparam int unsigned AUX_DRV_LM_BIT   = 4;
  localparam int unsigned AUX_RESISTIVE_MOD_ENABLE_BIT   = 3;
  localparam int unsigned AUX_SHAPED_BIT   = 2;
  localparam logic [7:0]  AUX_WRITE_MASK   = 8'hFC;

  // passive target register: modulated level high nibble, unmodulated low
  localparam int unsigned PTM_MOD_LSB   = 4;
  localparam int unsigned PTM_UNMOD_LSB = 0;

  // modulation level register: depth index bits 11:8, resistive level 6:0
  localparam int unsigned MODLVL_DEPTH_LSB = 8;
  localparam int unsigned MODLVL_RES_LSB   = 0;

  // reset values
  localparam logic [7:0] AUX_RESET       = 8'h10;
  localparam logic [7:0] PTM_RESET       = 8'h70;
  localparam logic [3:0] DEPTH_RESET     = 4'h7;
  localparam logic [6:0] RES_LEVEL_RESET = 7'h00;

  // drive level code that leaves the driver in high impedance
  localparam logic [3:0] LEVEL_HIZ = 4'hF;

  // modulation depth in percent for a depth index
  function automatic logic [6:0] depth_pct(input logic [3:0] code);
    logic [6:0] p;
    p = 7'h00;
    case (code)
      4'h0: p = 7'd0;
      4'h1: p = 7'd8;
      4'h2: p = 7'd10;
      4'h3: p = 7'd11;
      4'h4: p = 7'd12;
      4'h5: p = 7'd13;
      4'h6: p = 7'd14;
      4'h7: p = 7'd15;
      4'h8: p = 7'd20;
      4'h9: p = 7'd25;
      4'hA: p = 7'd30;
      4'hB: p = 7'd40;
      4'hC: p = 7'd50;
      4'hD: p = 7'd60;
      4'hE: p = 7'd70;
      default: p = 7'd82;
    endcase
    return p;
  endfunction

  // normalized drive resistance times ten; zero means high impedance
  function automatic logic [11:0] res_x10(input logic [3:0] code);
    logic [11:0] r;
    r = 12'h000;
    case (code)
      4'h0: r = 12'd10;
      4'h1: r = 12'd20;
      4'h2: r = 12'd41;
      4'h3: r = 12'd83;
      4'h4: r = 12'd122;
      4'h5: r = 12'd171;
      4'h6: r = 12'd256;
      4'h7: r = 12'd320;
      4'h8: r = 12'd366;
      4'h9: r = 12'd427;
      4'hA: r = 12'd512;
      4'hB: r = 12'd640;
      4'hC: r = 12'd853;
      4'hD: r = 12'd1280;
      4'hE: r = 12'd2560;
      default: r = 12'd0;
    endcase
    return r;
  endfunction

endpackage : rmc_pkg

`default_nettype wire

// ### common/rmc_cfg_if.sv
// rmc_cfg_if: configuration fields passed from the register bank to the
// drive selector. assumes both ends sit on the same clock.
`default_nettype none

interface rmc_cfg_if;
  logic       regulator_mod_off;           // regulator AM disable
  logic       pin_loadmod_polarity;        // pin active low when set
  logic       pin_loadmod_enable;          // pin carries load modulation
  logic       driver_loadmod_enable;       // load modulation via driver
  logic       resistive_mod_enable;        // resistive AM on
  logic       shaped_regulator_mod_enable; // shaped regulator AM on
  logic [3:0] modulated_drive_level;       // passive modulated level
  logic [3:0] unmodulated_drive_level;     // passive unmodulated level
  logic [3:0] mod_depth_index;             // regulator AM depth
  logic [6:0] resistive_mod_level;         // resistive AM level

  modport regs (
    output regulator_mod_off, pin_loadmod_polarity, pin_loadmod_enable,
           driver_loadmod_enable, resistive_mod_enable,
           shaped_regulator_mod_enable, modulated_drive_level,
           unmodulated_drive_level, mod_depth_index, resistive_mod_level
  );
  modport drv (
    input  regulator_mod_off, pin_loadmod_polarity, pin_loadmod_enable,
           driver_loadmod_enable, resistive_mod_enable,
           shaped_regulator_mod_enable, modulated_drive_level,
           unmodulated_drive_level, mod_depth_index, resistive_mod_level
  );
endinterface : rmc_cfg_if

`default_nettype wire

// ### hdl/rmc_drive_sel.sv
// rmc_drive_sel: combinational choice of the antenna driver setting from
// the configuration and the current modulation state.
// assumes the modulation inputs are on the register bank's clock.
`default_nettype none

module rmc_drive_sel (
  rmc_cfg_if.drv           cfg,
  input  wire logic        loadmod_signal,
  input  wire logic        tx_modulated,
  input  wire logic        passive_target_mode,
  output logic             pin_level,
  output logic             driver_lm_active,
  output logic             resistive_active,
  output logic [3:0]       level_code,
  output logic [11:0]      level_res_x10,
  output logic [6:0]       depth_pct
);

  // driver load modulation only counts in passive target mode
  assign driver_lm_active = cfg.driver_loadmod_enable & passive_target_mode;

  // resistive AM acts on transmitter modulated phases while driver load modulation is inactive
  assign resistive_active = cfg.resistive_mod_enable & tx_modulated
                          & ~driver_lm_active;

  // modulated phase takes the upper level, idle phase the lower one
  assign level_code = ~driver_lm_active ? 4'h0
                    : loadmod_signal ? cfg.modulated_drive_level
                    : cfg.unmodulated_drive_level;

  // monotonic table; code 15 reads as zero meaning high impedance
  assign level_res_x10 = rmc_pkg::res_x10(level_code);

  // polarity inverts the active level; disabled pin rests inactive
  assign pin_level = cfg.pin_loadmod_enable
                   ? (loadmod_signal ^ cfg.pin_loadmod_polarity)
                   : cfg.pin_loadmod_polarity;

  // depth is reported as zero while regulator AM is disabled
  assign depth_pct = cfg.regulator_mod_off ? 7'h00
                   : rmc_pkg::depth_pct(cfg.mod_depth_index);

endmodule // rmc_drive_sel

`default_nettype wire

// ### hdl/rmc_mod_config_regs.sv
// rmc_mod_config_regs: AHB-Lite register bank that configures how the
// transmitter modulates and how load modulation reaches the driver and pin.
// assumes a single AHB-Lite master, word transfers only, and modulation
// inputs produced by logic on the same clock (no synchronisers needed).
//
// Added by the designer: the AHB-Lite register port.
`default_nettype none

module rmc_mod_config_regs (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // ahb-lite slave port
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // modulation state from the transmitter and target logic
  input  wire logic        loadmod_signal,
  input  wire logic        tx_modulated,
  input  wire logic        passive_target_mode,
  // driver and pin controls
  output logic             loadmod_output_pin,
  output logic             regulator_mod_on,
  output logic             shaped_regulator_mod_on,
  output logic [6:0]       mod_depth_pct,
  output logic             driver_loadmod_active,
  output logic             resistive_mod_active,
  output logic [3:0]       drive_level_code,
  output logic [6:0]       resistive_level,
  output logic             drive_hiz,
  output logic [11:0]      drive_res_x10
);

  // bus phase tracking
  logic        dp_valid_q;      // a data phase is in progress
  logic        dp_valid_d;      // next data phase flag
  logic        dp_write_q;      // the pending data phase is a write
  logic        dp_write_d;      // next write flag
  logic [31:0] dp_addr_q;       // address captured in the address phase
  logic [31:0] dp_addr_d;       // next captured address
  logic [31:0] hrdata_q;        // read data register
  logic [31:0] hrdata_d;        // next read data

  // software registers
  logic [7:0]  aux_q;           // auxiliary modulation config
  logic [7:0]  aux_d;
  logic [7:0]  ptm_q;           // passive target drive levels
  logic [7:0]  ptm_d;
  logic [3:0]  depth_q;         // regulator AM depth index
  logic [3:0]  depth_d;
  logic [6:0]  res_lvl_q;       // resistive AM level
  logic [6:0]  res_lvl_d;

  // registered driver and pin outputs
  logic        pin_q;           // load modulation pin level
  logic        reg_on_q;        // regulator AM active
  logic        shaped_on_q;     // shaped regulator AM active
  logic [6:0]  depth_pct_q;     // reported modulation depth
  logic        drv_lm_q;        // driver load modulation active
  logic        res_act_q;       // resistive AM active
  logic [3:0]  code_q;          // driver level code
  logic [6:0]  res_out_q;       // resistive level driven out
  logic        hiz_q;           // driver in high impedance
  logic [11:0] res_x10_q;       // normalized resistance times ten

  // decode and selection wires
  logic        addr_accept;     // address phase taken this cycle
  logic        wr_now;          // write data phase completes this cycle
  logic        wr_aux;          // write hits the auxiliary register
  logic        wr_ptm;          // write hits the passive target register
  logic        wr_modlvl;       // write hits the modulation level register
  logic        rd_aux;          // read address selects auxiliary register
  logic        rd_ptm;          // read address selects passive register
  logic        rd_modlvl;       // read address selects level register
  logic        rd_status;       // read address selects status register
  logic [31:0] status_word;     // live status of the drive selection

  // results of the drive selector
  logic        sel_pin;
  logic        sel_drv_lm;
  logic        sel_res_act;
  logic [3:0]  sel_code;
  logic [11:0] sel_res_x10;
  logic [6:0]  sel_depth;

  rmc_cfg_if cfg_bus ();

  // the slave never stretches a transfer except while frozen, so the
  // master sees hready low whenever the clock enable drops
  assign hreadyout = clk_en;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // an address phase is taken on a valid non-sequential or sequential
  // transfer while the bus is ready and the block is not frozen
  assign addr_accept = hsel & htrans[1] & hready & clk_en;

  // the write lands in the data phase cycle where hwdata stands
  assign wr_now    = dp_valid_q & dp_write_q & clk_en;
  assign wr_aux    = wr_now & (dp_addr_q == rmc_pkg::AUX_ADDR);
  assign wr_ptm    = wr_now & (dp_addr_q == rmc_pkg::PTM_ADDR);
  assign wr_modlvl = wr_now & (dp_addr_q == rmc_pkg::MODLVL_ADDR);

  // read decode looks at the live address phase
  assign rd_aux    = haddr == rmc_pkg::AUX_ADDR;
  assign rd_ptm    = haddr == rmc_pkg::PTM_ADDR;
  assign rd_modlvl = haddr == rmc_pkg::MODLVL_ADDR;
  assign rd_status = haddr == rmc_pkg::STATUS_ADDR;

  // reserved low bits of the auxiliary register never store a one
  assign aux_d = wr_aux ? (hwdata[7:0] & rmc_pkg::AUX_WRITE_MASK)
                        : aux_q;

  // passive target levels are stored whole
  assign ptm_d = wr_ptm ? hwdata[7:0] : ptm_q;

  // depth index and resistive level share one word
  assign depth_d   = wr_modlvl
                   ? hwdata[rmc_pkg::MODLVL_DEPTH_LSB +: 4] : depth_q;
  assign res_lvl_d = wr_modlvl
                   ? hwdata[rmc_pkg::MODLVL_RES_LSB +: 7] : res_lvl_q;

  // next bus phase state
  assign dp_valid_d = addr_accept ? 1'b1 : (clk_en ? 1'b0 : dp_valid_q);
  assign dp_write_d = addr_accept ? hwrite : dp_write_q;
  assign dp_addr_d  = addr_accept ? haddr : dp_addr_q;

  // live state a driver engineer wants to see without a scope
  assign status_word = {16'h0000, hiz_q, res_act_q, drv_lm_q, pin_q,
                        code_q, 1'b0, depth_pct_q};

  // read data is picked from the next-state values so that a read right
  // behind a write to the same register returns the new contents
  assign hrdata_d = ~(addr_accept & ~hwrite) ? hrdata_q
                  : rd_aux    ? {24'h000000, aux_d}
                  : rd_ptm    ? {24'h000000, ptm_d}
                  : rd_modlvl ? {20'h00000, depth_d, 1'b0, res_lvl_d}
                  : rd_status ? status_word
                  : 32'h00000000;

  // fan the register fields out to the drive selector
  assign cfg_bus.regulator_mod_off           = aux_q[rmc_pkg::AUX_REG_OFF_BIT];
  assign cfg_bus.pin_loadmod_polarity        = aux_q[rmc_pkg::AUX_PIN_POL_BIT];
  assign cfg_bus.pin_loadmod_enable          = aux_q[rmc_pkg::AUX_PIN_EN_BIT];
  assign cfg_bus.driver_loadmod_enable       = aux_q[rmc_pkg::AUX_DRV_LM_BIT];
  assign cfg_bus.resistive_mod_enable        = aux_q[rmc_pkg::AUX_RESISTIVE_MOD_ENABLE_BIT];
  assign cfg_bus.shaped_regulator_mod_enable = aux_q[rmc_pkg::AUX_SHAPED_BIT];
  assign cfg_bus.modulated_drive_level       = ptm_q[rmc_pkg::PTM_MOD_LSB +: 4];
  assign cfg_bus.unmodulated_drive_level     = ptm_q[rmc_pkg::PTM_UNMOD_LSB +: 4];
  assign cfg_bus.mod_depth_index             = depth_q;
  assign cfg_bus.resistive_mod_level         = res_lvl_q;

  // the selector is pure logic; every output is registered below
  rmc_drive_sel u_drive_sel (
    .cfg                 (cfg_bus.drv),
    .loadmod_signal      (loadmod_signal),
    .tx_modulated        (tx_modulated),
    .passive_target_mode (passive_target_mode),
    .pin_level           (sel_pin),
    .driver_lm_active    (sel_drv_lm),
    .resistive_active    (sel_res_act),
    .level_code          (sel_code),
    .level_res_x10       (sel_res_x10),
    .depth_pct           (sel_depth)
  );

  // bus phase registers; frozen while clk_en is low
  always_ff @(posedge clk) begin
    if (rst) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q  <= 32'h00000000;
      hrdata_q   <= 32'h00000000;
    end else if (clk_en) begin
      dp_valid_q <= dp_valid_d;
      dp_write_q <= dp_write_d;
      dp_addr_q  <= dp_addr_d;
      hrdata_q   <= hrdata_d;
    end
  end

  // software registers; reset puts driver load modulation on and
  // regulator AM on, as a freshly powered front end expects
  always_ff @(posedge clk) begin
    if (rst) begin
      aux_q     <= rmc_pkg::AUX_RESET;
      ptm_q     <= rmc_pkg::PTM_RESET;
      depth_q   <= rmc_pkg::DEPTH_RESET;
      res_lvl_q <= rmc_pkg::RES_LEVEL_RESET;
    end else if (clk_en) begin
      aux_q     <= aux_d;
      ptm_q     <= ptm_d;
      depth_q   <= depth_d;
      res_lvl_q <= res_lvl_d;
    end
  end

  // mode enables follow the register with one cycle of latency
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_on_q    <= 1'b0;
      shaped_on_q <= 1'b0;
      depth_pct_q <= 7'h00;
    end else if (clk_en) begin
      reg_on_q    <= ~aux_q[rmc_pkg::AUX_REG_OFF_BIT];
      shaped_on_q <= aux_q[rmc_pkg::AUX_SHAPED_BIT];
      depth_pct_q <= sel_depth;
    end
  end

  // driver and pin controls; a glitch on these would reach the antenna,
  // so they come from flops rather than straight from the decode
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_q     <= 1'b0;
      drv_lm_q  <= 1'b0;
      res_act_q <= 1'b0;
      code_q    <= 4'h0;
      res_x10_q <= 12'h000;
      hiz_q     <= 1'b0;
      res_out_q <= 7'h00;
    end else if (clk_en) begin
      pin_q     <= sel_pin;
      drv_lm_q  <= sel_drv_lm;
      res_act_q <= sel_res_act;
      code_q    <= sel_code;
      res_x10_q <= sel_res_x10;
      hiz_q     <= sel_drv_lm & (sel_code == rmc_pkg::LEVEL_HIZ);
      res_out_q <= sel_res_act ? res_lvl_q : 7'h00;
    end
  end

  // outputs straight from the flops above
  assign loadmod_output_pin      = pin_q;
  assign regulator_mod_on        = reg_on_q;
  assign shaped_regulator_mod_on = shaped_on_q;
  assign mod_depth_pct           = depth_pct_q;
  assign driver_loadmod_active   = drv_lm_q;
  assign resistive_mod_active    = res_act_q;
  assign drive_level_code        = code_q;
  assign resistive_level         = res_out_q;
  assign drive_hiz               = hiz_q;
  assign drive_res_x10           = res_x10_q;

endmodule // rmc_mod_config_regs

`default_nettype wire

// ### testbench/rmc_checker.sv
// rmc_checker: concurrent checks on the modulation register bank's pins.
// assumes one clock domain and a synchronous, active high reset.
`default_nettype none

module rmc_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        passive_target_mode,
  input wire logic        tx_modulated,
  input wire logic        regulator_mod_on,
  input wire logic [6:0]  mod_depth_pct,
  input wire logic        driver_loadmod_active,
  input wire logic        resistive_mod_active,
  input wire logic [3:0]  drive_level_code,
  input wire logic        drive_hiz,
  input wire logic [11:0] drive_res_x10
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // first running edge after reset lets go
  sequence release_s;
    $fell(rst) ##0 clk_en;
  endsequence
  // a running edge with the target path off
  sequence no_target_s;
    clk_en && !passive_target_mode;
  endsequence

  // zero wait states: ready simply mirrors the enable
  ready_echo_a: assert property (hreadyout == clk_en)
    else $error("hreadyout does not follow clk_en");
  okay_only_a: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  reset_depth_a: assert property (release_s |=>
    regulator_mod_on && mod_depth_pct == 7'd15)
    else $error("depth after reset wrong");
  depth_off_a: assert property (!regulator_mod_on |-> mod_depth_pct == 7'd0)
    else $error("depth nonzero with regulator off");
  depth_max_a: assert property (mod_depth_pct <= 7'd82)
    else $error("depth above ceiling");
  target_gate_a: assert property (no_target_s |=> !driver_loadmod_active)
    else $error("driver load modulation outside target mode");
  idle_code_a: assert property (!driver_loadmod_active |-> drive_level_code == 4'h0)
    else $error("drive code while driver load modulation off");
  resist_gate_a: assert property (clk_en && !tx_modulated |=> !resistive_mod_active)
    else $error("resistive modulation without modulated phase");
  hiz_code_a: assert property (drive_hiz |->
    drive_level_code == 4'hF && drive_res_x10 == 12'd0)
    else $error("high impedance with wrong code");
  top_code_a: assert property (drive_level_code == 4'hE |-> drive_res_x10 == 12'd2560)
    else $error("code 14 resistance wrong");
endmodule // rmc_checker

bind rmc_mod_config_regs rmc_checker i_rmc_checker (
  .clk(clk), .rst(rst), .clk_en(clk_en), .hreadyout(hreadyout), .hresp(hresp),
  .passive_target_mode(passive_target_mode), .tx_modulated(tx_modulated),
  .regulator_mod_on(regulator_mod_on), .mod_depth_pct(mod_depth_pct),
  .driver_loadmod_active(driver_loadmod_active),
  .resistive_mod_active(resistive_mod_active), .drive_level_code(drive_level_code),
  .drive_hiz(drive_hiz), .drive_res_x10(drive_res_x10)
);

`default_nettype wire

// ### testbench/rmc_tx_model.sv
// rmc_tx_model: transmitter and target logic feeding the modulation state.
// assumes the bench requests modes; outputs are registered on clk.
`default_nettype none

module rmc_tx_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic target_req,
  input  wire logic modulate_req,
  input  wire logic carrier_mod_req,
  output logic      passive_target_mode,
  output logic      loadmod_signal,
  output logic      tx_modulated
);
  // registered like real sequencing logic, never combinational pass-through
  always_ff @(posedge clk) begin
    if (rst) begin
      passive_target_mode <= 1'b0;
      loadmod_signal      <= 1'b0;
      tx_modulated        <= 1'b0;
    end else begin
      passive_target_mode <= target_req;                  // entered only once asked
      loadmod_signal      <= modulate_req & target_req;    // answers only as a target
      tx_modulated        <= carrier_mod_req & ~target_req; // reader phase excludes target
    end
  end
endmodule // rmc_tx_model

`default_nettype wire

// ### testbench/rmc_mod_config_regs_tb.sv
// rmc_mod_config_regs_tb: self-checking bench for the modulation registers.
// assumes the checker is bound by its own file; one AHB-Lite master here.
`default_nettype none

module rmc_mod_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, clk_en = 1'b1;    // clock, reset, enable
  logic        hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;  // bus address and data
  logic        target_req = 1'b0, modulate_req = 1'b0, carrier_mod_req = 1'b0;
  logic        loadmod_signal, tx_modulated, passive_target_mode, loadmod_output_pin;
  logic        regulator_mod_on, shaped_regulator_mod_on, driver_loadmod_active;
  logic        resistive_mod_active, drive_hiz;
  logic [6:0]  mod_depth_pct, resistive_level;
  logic [3:0]  drive_level_code;
  logic [11:0] drive_res_x10;
  int          fails = 0, n_compared = 0, cycles = 0;

  always #50 clk = ~clk;                                // 10 MHz

  rmc_mod_config_regs i_rmc_mod_config_regs (
    .clk(clk), .rst(rst), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .loadmod_signal(loadmod_signal),
    .tx_modulated(tx_modulated), .passive_target_mode(passive_target_mode),
    .loadmod_output_pin(loadmod_output_pin), .regulator_mod_on(regulator_mod_on),
    .shaped_regulator_mod_on(shaped_regulator_mod_on), .mod_depth_pct(mod_depth_pct),
    .driver_loadmod_active(driver_loadmod_active),
    .resistive_mod_active(resistive_mod_active), .drive_level_code(drive_level_code),
    .resistive_level(resistive_level), .drive_hiz(drive_hiz), .drive_res_x10(drive_res_x10));

  rmc_tx_model i_rmc_tx_model (
    .clk(clk), .rst(rst), .target_req(target_req), .modulate_req(modulate_req),
    .carrier_mod_req(carrier_mod_req), .passive_target_mode(passive_target_mode),
    .loadmod_signal(loadmod_signal), .tx_modulated(tx_modulated));

  // verdict and end of run, reached from the main sequence or the timeout
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // the one compare for every result, widened to a word
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // let two register stages land; sampling at an edge sees settled values
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  // single word transfer; address phase held until ready, data taken at 2nd edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(what, e, q);
  endtask

  // reset values seen on the bus and at the driver controls
  task automatic t_reset();
    rd_chk("aux reset", rmc_pkg::AUX_ADDR, 32'h10);
    rd_chk("passive reset", rmc_pkg::PTM_ADDR, 32'h70);
    chk("regulator on", 32'h1, {31'h0, regulator_mod_on});
    chk("depth reset", 32'hF, {25'h0, mod_depth_pct});
    chk("shaped off", 32'h0, {31'h0, shaped_regulator_mod_on});
  endtask

  // all ones: reserved bits drop, regulator off, shaped on
  task automatic t_aux();
    wr(rmc_pkg::AUX_ADDR, 32'hFF);                           // sink assumed off here
    rd_chk("aux readback", rmc_pkg::AUX_ADDR, 32'hFC);
    settle();
    chk("regulator off", 32'h0, {31'h0, regulator_mod_on});
    chk("depth off", 32'h0, {25'h0, mod_depth_pct});
    chk("shaped on", 32'h1, {31'h0, shaped_regulator_mod_on});
    wr(rmc_pkg::AUX_ADDR, 32'h10);                           // shaping cleared again
  endtask

  // passive target: unmodulated, modulated, high impedance, then driver path off
  task automatic t_passive();
    wr(rmc_pkg::PTM_ADDR, 32'hE0);                           // levels first
    rd_chk("passive readback", rmc_pkg::PTM_ADDR, 32'hE0);
    target_req <= 1'b1;
    settle();
    chk("driver lm on", 32'h1, {31'h0, driver_loadmod_active});
    chk("unmod code", 32'h0, {28'h0, drive_level_code});
    chk("unmod res", 32'd10, {20'h0, drive_res_x10});
    modulate_req <= 1'b1;
    settle();
    chk("mod code", 32'hE, {28'h0, drive_level_code});
    chk("mod res", 32'd2560, {20'h0, drive_res_x10});
    wr(rmc_pkg::PTM_ADDR, 32'hF0);
    settle();
    chk("hiz", 32'h1, {31'h0, drive_hiz});
    rd_chk("status", rmc_pkg::STATUS_ADDR, 32'hAF0F);
    wr(rmc_pkg::AUX_ADDR, 32'h00);                           // sink assumed on here
    settle();
    chk("driver lm off", 32'h0, {31'h0, driver_loadmod_active});
  endtask

  // every enable/polarity pair against both modulation levels
  task automatic t_pin();
    logic [31:0] exp;
    for (int i = 0; i < 8; i++) begin
      wr(rmc_pkg::AUX_ADDR, {25'h0, i[2:1], 5'h10});
      modulate_req <= i[0];
      settle();
      exp = {31'h0, i[1] ? (i[0] ^ i[2]) : i[2]};            // rests at inactive level
      chk("pin level", exp, {31'h0, loadmod_output_pin});
    end
    modulate_req <= 1'b0;
    target_req <= 1'b0;
  endtask

  // resistive modulation and the depth ceiling
  task automatic t_resist();
    carrier_mod_req <= 1'b1;
    wr(rmc_pkg::MODLVL_ADDR, 32'hF55);
    rd_chk("level readback", rmc_pkg::MODLVL_ADDR, 32'hF55);
    wr(rmc_pkg::AUX_ADDR, 32'h08);
    settle();
    chk("resistive on", 32'h1, {31'h0, resistive_mod_active});
    chk("resistive lvl", 32'h55, {25'h0, resistive_level});
    chk("depth top", 32'd82, {25'h0, mod_depth_pct});
    carrier_mod_req <= 1'b0;
    settle();
    chk("resistive off", 32'h0, {31'h0, resistive_mod_active});
  endtask

  // stalled bus, then an unmapped write must not disturb anything
  task automatic t_unmapped();
    clk_en <= 1'b0;
    repeat (2) @(posedge clk);
    chk("stalled ready", 32'h0, {31'h0, hreadyout});
    clk_en <= 1'b1;
    wr(32'h100, 32'hFF);
    rd_chk("unmapped", 32'h100, 32'h0);
    rd_chk("aux kept", rmc_pkg::AUX_ADDR, 32'h08);
  endtask

  // hang guard: the whole run needs well under 3000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      fails++;
      test_done();
    end
  end

  // reset, scenarios, a second reset, verdict
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_aux();
    t_passive();
    t_pin();
    t_resist();
    t_unmapped();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    test_done();
  end
endmodule // rmc_mod_config_regs_tb

`default_nettype wire
